/* File: hdl/smc_consts.svh */
// Purpose: Constants for the stop mode controller.
// Assumes: Core clock of 100 MHz.
// Notes: Definitions only.
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
`define SMC_LONG_DELAY 4064
`define SMC_SHORT_DELAY 4
`define SMC_SP_WAIT_OFFSET 16'h0008
`define SMC_PORT_RESET_VALUE 8'h00
`endif

/* File: hdl/smc_pkg.sv */
// Purpose: Types for the stop mode controller.
// Assumes: Nothing beyond the constants header.
// Notes: States of the low-power sequencer.
package smc_pkg;
    typedef enum logic [1:0] {
        SMC_RUN = 2'b00,
        SMC_WAIT = 2'b01,
        SMC_STOP = 2'b10,
        SMC_RESTART = 2'b11
    } smc_state_e;
    typedef enum logic [1:0] {
        SMC_RESUME_NEXT = 2'b00,
        SMC_RESUME_NMI = 2'b01,
        SMC_RESUME_IRQ = 2'b10,
        SMC_RESUME_RESET = 2'b11
    } smc_resume_e;
endpackage

/* File: hdl/smc_stop_mode_controller.sv */
// Purpose: Stop and wait state sequencing and pin state control.
// Assumes: Core issues opcode pulses on the same clock; pins are synchronised here.
// Notes: Clocks are halted by a gate enable output, not by stopping clk itself.
//
// Behaviour
// (RULE1) Stop opcode enters stop only when the stop-disable bit is zero.
// (RULE2) Stop opcode with stop-disable set acts as a no-operation.
// (RULE3) In stop, all clocks including the oscillator are halted.
// (RULE4) Stop ends on reset, non-maskable pin, or an unmasked maskable request.
// (RULE5) Non-maskable pin wakes from stop regardless of its mask bit.
// (RULE6) Non-maskable wake with mask clear stacks state then services it.
// (RULE7) Non-maskable wake with mask set resumes after stop, no service.
// (RULE8) Reset in stop ends stop; execution restarts from the reset vector.
// (RULE9) Wake-up waits a 4064 cycle restart delay before resuming.
// (RULE10) With the internal oscillator the full delay always applies.
// (RULE11) Delay select zero shortens recovery to four cycles for stable clocks.
// (RULE12) Single-chip wait and stop hold output ports and strobe steady; the code lets multiplexed_addr_data_port follow mux_port_run.
// (RULE13) Expanded wait drives address/data port with captured stack pointer minus 8.
// (RULE14) Port pins keep their data-direction setting in wait and stop.
// (RULE15) In stop bus clock is low; expanded holds address strobe low, read level.
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_stop_mode_controller #(
    parameter int LONG_DELAY = `SMC_LONG_DELAY,
    parameter int SHORT_DELAY = `SMC_SHORT_DELAY
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic stop_opcode,
    input wire logic low_power_idle_opcode,
    input wire logic stop_disable,
    input wire logic nmi_mask,
    input wire logic irq_mask,
    input wire logic nonmaskable_interrupt_pin_n,
    input wire logic irq_pin_n,
    input wire logic restart_delay_select,
    input wire logic internal_osc,
    input wire logic expanded_mode,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] bus_address,
    input wire logic bus_clock_run,
    input wire logic address_strobe_run,
    input wire logic read_write_run,
    input wire logic strobe_run,
    input wire logic [7:0] out_port_run,
    input wire logic [7:0] high_addr_run,
    input wire logic [7:0] mux_port_run,
    input wire logic [7:0] mux_port_dir,
    output smc_pkg::smc_state_e state,
    output logic clock_gate_en,
    output logic osc_enable,
    output logic nop_done,
    output logic resume_pulse,
    output smc_pkg::smc_resume_e resume_kind,
    output logic bus_clock,
    output logic strobe_or_read_write_pin,
    output logic strobe_in_or_address_strobe,
    output logic [7:0] out_port,
    output logic [7:0] high_address_port,
    output logic [7:0] multiplexed_addr_data_port,
    output logic [7:0] multiplexed_addr_data_port_oe_n
);
    import smc_pkg::*;

    // Refused at elaboration, since the restart counter is only sixteen bits wide.
    if (LONG_DELAY < SHORT_DELAY || SHORT_DELAY < 1 || LONG_DELAY > 65535) begin : g_param_check
        $error("Restart delay parameters out of range.");
    end

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic nmi_meta, nmi_sync, irq_meta, irq_sync;
    always_ff @(posedge clk) begin
        if (rst) begin
            nmi_meta <= 1'b1;
            nmi_sync <= 1'b1;
            irq_meta <= 1'b1;
            irq_sync <= 1'b1;
        end else begin
            nmi_meta <= nonmaskable_interrupt_pin_n;
            nmi_sync <= nmi_meta;
            irq_meta <= irq_pin_n;
            irq_sync <= irq_meta;
        end
    end

    logic nmi_wake, irq_wake;
    assign nmi_wake = !nmi_sync; // [RULE5]
    assign irq_wake = !irq_sync && !irq_mask;

    // ************************************************************
    // Sequencer
    // ************************************************************
    // The long delay is forced with the internal oscillator, since it cannot be stable yet.
    logic use_short;
    logic [15:0] delay_cnt;
    logic [15:0] sp_capture;
    assign use_short = !restart_delay_select && !internal_osc; // [RULE10] [RULE11]

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= SMC_RUN; // [RULE8]
            delay_cnt <= 16'h0000;
            resume_kind <= SMC_RESUME_RESET;
            resume_pulse <= 1'b0;
            nop_done <= 1'b0;
        end else begin
            resume_pulse <= 1'b0;
            nop_done <= 1'b0;
            case (state)
                SMC_RUN: begin
                    if (stop_opcode && !stop_disable) begin
                        state <= SMC_STOP; // [RULE1]
                    end else if (stop_opcode) begin
                        nop_done <= 1'b1; // [RULE2]
                    end else if (low_power_idle_opcode) begin
                        state <= SMC_WAIT;
                    end
                end
                SMC_WAIT: begin
                    if (nmi_wake && !nmi_mask) begin
                        state <= SMC_RUN;
                        resume_kind <= SMC_RESUME_NMI;
                        resume_pulse <= 1'b1;
                    end else if (irq_wake) begin
                        state <= SMC_RUN;
                        resume_kind <= SMC_RESUME_IRQ;
                        resume_pulse <= 1'b1;
                    end
                end
                SMC_STOP: begin
                    if (nmi_wake || irq_wake) begin // [RULE4]
                        state <= SMC_RESTART;
                        delay_cnt <= use_short ? 16'(SHORT_DELAY - 1) : 16'(LONG_DELAY - 1); // [RULE9]
                        if (nmi_wake) begin
                            resume_kind <= nmi_mask ? SMC_RESUME_NEXT : SMC_RESUME_NMI; // [RULE6] [RULE7]
                        end else begin
                            resume_kind <= SMC_RESUME_IRQ;
                        end
                    end
                end
                SMC_RESTART: begin
                    if (delay_cnt == 16'h0000) begin
                        state <= SMC_RUN;
                        resume_pulse <= 1'b1;
                    end else begin
                        delay_cnt <= delay_cnt - 16'h0001;
                    end
                end
                default: state <= SMC_RUN;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sp_capture <= 16'h0000;
        end else if (state == SMC_RUN && low_power_idle_opcode) begin
            sp_capture <= stack_pointer - `SMC_SP_WAIT_OFFSET; // [RULE13]
        end
    end

    // ************************************************************
    // Clock control and pin states
    // ************************************************************
    logic in_stop, low_power;
    assign in_stop = (state == SMC_STOP);
    assign low_power = (state != SMC_RUN) && (state != SMC_RESTART);

    always_ff @(posedge clk) begin
        if (rst) begin
            clock_gate_en <= 1'b1;
            osc_enable <= 1'b1;
        end else begin
            clock_gate_en <= !(in_stop || (state == SMC_RUN && stop_opcode && !stop_disable)); // [RULE3]
            osc_enable <= !in_stop; // [RULE3]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_clock <= 1'b0;
            strobe_or_read_write_pin <= 1'b0;
            strobe_in_or_address_strobe <= 1'b0;
            out_port <= `SMC_PORT_RESET_VALUE;
            high_address_port <= `SMC_PORT_RESET_VALUE;
            multiplexed_addr_data_port <= `SMC_PORT_RESET_VALUE;
            multiplexed_addr_data_port_oe_n <= 8'hFF;
        end else begin
            bus_clock <= in_stop ? 1'b0 : bus_clock_run; // [RULE15]
            if (!low_power) begin
                out_port <= out_port_run;
            end // [RULE12]
            if (expanded_mode) begin
                strobe_or_read_write_pin <= low_power ? 1'b1 : read_write_run; // [RULE15]
                strobe_in_or_address_strobe <= in_stop ? 1'b0 : address_strobe_run; // [RULE15]
                high_address_port <= low_power ? bus_address[15:8] : high_addr_run;
                multiplexed_addr_data_port_oe_n <= 8'h00;
                if (state == SMC_WAIT) begin
                    multiplexed_addr_data_port <= sp_capture[7:0]; // [RULE13]
                end else if (in_stop) begin
                    multiplexed_addr_data_port <= bus_address[7:0];
                end else begin
                    multiplexed_addr_data_port <= mux_port_run;
                end
            end else begin
                strobe_in_or_address_strobe <= 1'b0;
                if (!low_power) begin
                    strobe_or_read_write_pin <= strobe_run;
                    high_address_port <= high_addr_run;
                end // [RULE12]
                multiplexed_addr_data_port <= mux_port_run;
                multiplexed_addr_data_port_oe_n <= ~mux_port_dir; // [RULE14]
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    chk_stop_entry_gate: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        (state == SMC_RUN && stop_opcode && !stop_disable) |=> state == SMC_STOP)
        else $error("Stop not entered.");
    chk_stop_nop: assert property (@(posedge clk) disable iff (rst) // [RULE2]
        (state == SMC_RUN && stop_opcode && stop_disable) |=> state == SMC_RUN && nop_done)
        else $error("Disabled stop not a nop.");
    chk_clocks_halted: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        $past(state == SMC_STOP) && state == SMC_STOP |-> !clock_gate_en && !osc_enable)
        else $error("Clocks running in stop.");
    chk_wake_exit: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        (state == SMC_STOP && (irq_wake || nmi_wake)) |=> state == SMC_RESTART)
        else $error("Wake did not leave stop.");
    chk_nmi_masked_resume: assert property (@(posedge clk) disable iff (rst) // [RULE7]
        (state == SMC_STOP && nmi_wake && nmi_mask) |=> resume_kind == SMC_RESUME_NEXT)
        else $error("Masked nmi wake wrong.");
    chk_nmi_service: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        (state == SMC_STOP && nmi_wake && !nmi_mask) |=> resume_kind == SMC_RESUME_NMI)
        else $error("Nmi wake not serviced.");
    chk_short_delay: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        (state == SMC_STOP && irq_wake && !nmi_wake && use_short) |=> ##4 resume_pulse)
        else $error("Short delay wrong.");
    chk_long_load: assert property (@(posedge clk) disable iff (rst) // [RULE9]
        (state == SMC_STOP && (irq_wake || nmi_wake) && !use_short)
        |=> delay_cnt == 16'(LONG_DELAY - 1))
        else $error("Long delay not loaded.");
    chk_stop_bus_clock: assert property (@(posedge clk) disable iff (rst) // [RULE15]
        $past(state == SMC_STOP) |-> !bus_clock)
        else $error("Bus clock running in stop.");
    chk_stop_port_hold: assert property (@(posedge clk) disable iff (rst) // [RULE12]
        $past(state == SMC_STOP) && state == SMC_STOP |-> $stable(out_port))
        else $error("Output port moved in stop.");
endmodule

/* File: dv/smc_irq_source.sv */
// Purpose: Model of the external interrupt sources at the far side of the block.
// Assumes: Both request lines carry pull-ups, so a released source reads high.
// Notes: Requests change only just after a rising edge and are held as levels.
`timescale 1ns/1ps
module smc_irq_source (
    input wire logic clk,
    input wire logic nmi_req,
    input wire logic irq_req,
    output logic nonmaskable_interrupt_pin_n,
    output logic irq_pin_n
);
    // The lines are active low; with no request the pull-up keeps them high.
    always_ff @(posedge clk) begin
        nonmaskable_interrupt_pin_n <= !nmi_req;
        irq_pin_n <= !irq_req;
    end
endmodule

/* File: dv/test_stop_mode_controller.sv */
// Purpose: Self-checking bench for the stop mode controller.
// Assumes: A shortened long delay of 16 cycles keeps the run brief.
// Notes: Wake sources come from the interrupt source model.
`timescale 1ns/1ps
module test_stop_mode_controller;
    import smc_pkg::*;
    `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
    localparam int LONG = 16;
    localparam int SHORT = 4;
    typedef struct {logic sd; logic xm; logic nmi; logic dsel; logic osc;
        smc_resume_e kind; int delay;} smc_tb_row_s;
    logic clk = 0, rst = 1, stop_opcode = 0, idle_op = 0, stop_disable = 0;
    logic nmi_mask = 0, irq_mask = 0, nmi_req = 0, irq_req = 0, delay_sel = 1, int_osc = 0;
    logic exp_mode = 0, strobe_run = 1, bus_run = 1, nop_seen, nmi_n, irq_n;
    logic [15:0] sp = 16'h1234, addr = 16'hBEEF;
    logic [7:0] out_run = 8'hA5, dir = 8'h0F, out_port, hi_port, mux_port, mux_oe_n;
    logic clock_gate_en, osc_enable, nop_done, resume_pulse, bus_clock, srw_pin, sas_pin;
    smc_state_e state;
    smc_resume_e resume_kind;
    int mismatches = 0, cmp_count = 0, n;
    smc_tb_row_s rows[6] = '{
        '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, SMC_RESUME_NEXT, 0},
        '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, SMC_RESUME_NMI, LONG},
        '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, SMC_RESUME_NEXT, LONG},
        '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, SMC_RESUME_IRQ, SHORT},
        '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, SMC_RESUME_IRQ, LONG},
        '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, SMC_RESUME_NEXT, SHORT}};

    always #5 clk = ~clk;

    smc_irq_source src (.clk(clk), .nmi_req(nmi_req), .irq_req(irq_req),
        .nonmaskable_interrupt_pin_n(nmi_n), .irq_pin_n(irq_n));

    smc_stop_mode_controller #(.LONG_DELAY(LONG), .SHORT_DELAY(SHORT)) dut (
        .clk(clk), .rst(rst), .stop_opcode(stop_opcode), .low_power_idle_opcode(idle_op),
        .stop_disable(stop_disable), .nmi_mask(nmi_mask), .irq_mask(irq_mask),
        .nonmaskable_interrupt_pin_n(nmi_n), .irq_pin_n(irq_n),
        .restart_delay_select(delay_sel), .internal_osc(int_osc), .expanded_mode(exp_mode),
        .stack_pointer(sp), .bus_address(addr), .bus_clock_run(bus_run),
        .address_strobe_run(strobe_run), .read_write_run(~strobe_run),
        .strobe_run(strobe_run), .out_port_run(out_run), .high_addr_run(sp[15:8]),
        .mux_port_run(sp[7:0]), .mux_port_dir(dir), .state(state),
        .clock_gate_en(clock_gate_en), .osc_enable(osc_enable), .nop_done(nop_done),
        .resume_pulse(resume_pulse), .resume_kind(resume_kind), .bus_clock(bus_clock),
        .strobe_or_read_write_pin(srw_pin), .strobe_in_or_address_strobe(sas_pin),
        .out_port(out_port), .high_address_port(hi_port),
        .multiplexed_addr_data_port(mux_port), .multiplexed_addr_data_port_oe_n(mux_oe_n));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic pulse_stop();
        nop_seen = 1'b0;
        @(posedge clk) stop_opcode <= 1'b1;
        @(posedge clk) stop_opcode <= 1'b0;
        #1 nop_seen = (nop_done === 1'b1);
        repeat (3) begin
            @(posedge clk);
            #1 nop_seen = nop_seen | (nop_done === 1'b1);
        end
    endtask

    // Stops at the cycle of the resume pulse, so the caller can still look at it.
    task automatic wake(input logic nmi, input logic irq, output int cnt);
        cnt = 0;
        @(posedge clk);
        nmi_req <= nmi;
        irq_req <= irq;
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            #1 if (state === SMC_RESTART) cnt++;
            if (resume_pulse === 1'b1) break;
        end
    endtask

    task automatic summarize();
        if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #100us mismatches++;
        summarize();
    end

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 `CHK(state, SMC_RUN)
        `CHK(resume_kind, SMC_RESUME_RESET)
        foreach (rows[i]) begin
            @(posedge clk);
            {stop_disable, nmi_mask, delay_sel, int_osc} <= {rows[i].sd, rows[i].xm,
                rows[i].dsel, rows[i].osc};
            pulse_stop();
            if (rows[i].sd) begin
                `CHK(nop_seen, 1'b1)
                `CHK(state, SMC_RUN)
            end else begin
                `CHK(state, SMC_STOP)
                `CHK({clock_gate_en, osc_enable, bus_clock}, 3'b000)
                wake(rows[i].nmi, !rows[i].nmi, n);
                `CHK(resume_pulse, 1'b1)
                `CHK(resume_kind, rows[i].kind)
                `CHK(n, rows[i].delay)
                `CHK(bus_clock, 1'b1)
                @(posedge clk) {nmi_req, irq_req} <= 2'b00;
            end
        end
        // A masked request must leave the device stopped; reset still ends it.
        @(posedge clk) irq_mask <= 1'b1;
        pulse_stop();
        @(posedge clk) irq_req <= 1'b1;
        repeat (10) @(posedge clk);
        #1 `CHK(state, SMC_STOP)
        @(posedge clk) {rst, irq_req, irq_mask} <= 3'b100;
        @(posedge clk) rst <= 1'b0;
        @(posedge clk);
        #1 `CHK(state, SMC_RUN)
        `CHK(resume_kind, SMC_RESUME_RESET)
        // Single-chip stop: outputs hold while their running values move on.
        pulse_stop();
        @(posedge clk) {out_run, strobe_run} <= {8'h3C, 1'b0};
        repeat (2) @(posedge clk);
        #1 `CHK(out_port, 8'hA5)
        `CHK(srw_pin, 1'b1)
        `CHK(mux_oe_n, 8'hF0)
        wake(1'b1, 1'b0, n);
        @(posedge clk) {nmi_req, exp_mode, out_run, strobe_run} <= {2'b01, 8'hA5, 1'b1};
        // Expanded wait shows the stack pointer less eight on the low port.
        @(posedge clk) idle_op <= 1'b1;
        @(posedge clk) idle_op <= 1'b0;
        repeat (3) @(posedge clk);
        #1 `CHK(state, SMC_WAIT)
        `CHK(mux_port, 8'h2C)
        wake(1'b0, 1'b1, n);
        `CHK(resume_pulse, 1'b1)
        `CHK(resume_kind, SMC_RESUME_IRQ)
        // The released request takes three edges to leave the synchroniser, else it wakes the stop.
        @(posedge clk) irq_req <= 1'b0;
        repeat (2) @(posedge clk);
        pulse_stop();
        `CHK({sas_pin, srw_pin, bus_clock}, 3'b010)
        `CHK({hi_port, mux_port}, 16'hBEEF)
        wake(1'b1, 1'b0, n);
        `CHK(resume_pulse, 1'b1)
        summarize();
    end
endmodule
